/* File: src/dmu_pkg.sv */
package dmu_pkg;
   // ----------------------------------------------------------------
   // Clock and rates
   // ----------------------------------------------------------------
   localparam int unsigned CORE_CLK_HZ = 20_000_000;
   localparam int unsigned OSC_PER_SHIFT_BIT = 12;
   localparam int unsigned OVERSAMPLE = 16;
   localparam int unsigned FIXED_DIV_SLOW = 64;
   localparam int unsigned FIXED_DIV_FAST = 32;
   localparam logic [3:0] SHIFT_DIV_LAST = 4'(OSC_PER_SHIFT_BIT - 1);
   localparam logic [3:0] SHIFT_CLK_RISE = 4'(OSC_PER_SHIFT_BIT / 2);
   localparam logic [3:0] SHIFT_SAMPLE = 4'(OSC_PER_SHIFT_BIT / 2 + 2);
   localparam logic [1:0] FIX_LAST_SLOW = 2'(FIXED_DIV_SLOW / OVERSAMPLE - 1);
   localparam logic [1:0] FIX_LAST_FAST = 2'(FIXED_DIV_FAST / OVERSAMPLE - 1);
   localparam logic [3:0] OVS_LAST = 4'(OVERSAMPLE - 1);
   localparam logic [3:0] OVS_HALF = 4'(OVERSAMPLE / 2 - 1);

   // ----------------------------------------------------------------
   // Register map: address bit 1 picks the port, bit 0 the register
   // ----------------------------------------------------------------
   localparam logic [1:0] ADDR_PORT0_CTRL = 2'h0;
   localparam logic [1:0] ADDR_PORT0_DATA = 2'h1;
   localparam logic [1:0] ADDR_PORT1_CTRL = 2'h2;
   localparam logic [1:0] ADDR_PORT1_DATA = 2'h3;
   localparam int unsigned ADDR_DATA_BIT = 0;
   localparam int unsigned ADDR_PORT_BIT = 1;

   // ----------------------------------------------------------------
   // Fields of port_control_status
   // ----------------------------------------------------------------
   localparam int unsigned MODE_SELECT_A = 7;
   localparam int unsigned MODE_SELECT_B = 6;
   localparam int unsigned ADDR_FILTER_EN = 5;
   localparam int unsigned RX_ENABLE = 4;
   localparam int unsigned TX_NINTH_BIT = 3;
   localparam int unsigned RX_NINTH_BIT = 2;
   localparam int unsigned TX_DONE_FLAG = 1;
   localparam int unsigned RX_DONE_FLAG = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // Mode code is {mode_select_a, mode_select_b}
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_ASYNC10 = 2'h1;
   localparam logic [1:0] MODE_FIXED11 = 2'h2;
   localparam logic [1:0] MODE_VAR11 = 2'h3;
   localparam logic [3:0] BITS_SHIFT = 4'h8;
   localparam logic [3:0] BITS_TX10 = 4'hA;
   localparam logic [3:0] BITS_TX11 = 4'hB;
   localparam logic [3:0] BITS_RX10 = 4'h9;
   localparam logic [3:0] BITS_RX11 = 4'hA;

   typedef enum logic [2:0] {
      DMU_TX_IDLE = 3'b001,
      DMU_TX_WAIT = 3'b010,
      DMU_TX_SEND = 3'b100
   } dmu_tx_state_t;

   typedef enum logic [2:0] {
      DMU_RX_IDLE = 3'b001,
      DMU_RX_ASYNC = 3'b010,
      DMU_RX_SHIFT = 3'b100
   } dmu_rx_state_t;
endpackage

/* File: src/dmu_uart.sv */
// Behaviour
// - Two identical, independently controlled serial ports
// - Full duplex; receive buffered, overrun loses one
// - Data write loads transmitter, read gives receiver
// - Shift mode: data on rx pin, clock on tx
// - Ten-bit frame; stop bit stored as ninth
// - Eleven-bit frame with programmable ninth bit
// - Fixed eleven-bit rate osc/64 or osc/32
// - Variable eleven-bit mode uses timer rate
// - Data buffer write always starts transmission
// - Reception start conditions per mode
// - Filtering drops characters with ninth bit zero
// - Ten-bit filtering needs valid stop bit
// - Mode decoded from two mode-select bits
// - Transmit-done timing; only software clears
// - Receive-done timing; only software clears
// - Ninth field unused in shift mode
// - First timer rate times doubler over 32
// - Second timer rate divided by sixteen
`timescale 1ns/100ps
`default_nettype none

module dmu_port (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ctrl_wr,
   input wire logic data_wr,
   input wire logic [7:0] wdata,
   input wire logic baud_doubler,
   input wire logic tx_rate_source,
   input wire logic rx_rate_source,
   input wire logic timer1_ovf,
   input wire logic timer2_ovf,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd_out,
   output logic [7:0] ctrl_q,
   output logic [7:0] rbuf_q
);
   import dmu_pkg::*;

   // ----------------------------------------------------------------
   // Mode decode and rate ticks
   // ----------------------------------------------------------------
   dmu_tx_state_t tx_state_q;
   dmu_rx_state_t rx_state_q;
   logic [3:0] sdiv_q;
   logic [1:0] fdiv_q;
   logic t1_half_q;
   logic [3:0] tx_ovs_q;
   logic [3:0] rx_div_q;
   logic [10:0] tx_shift_q;
   logic [3:0] tx_left_q;
   logic tx_line_q;
   logic [9:0] rx_shift_q;
   logic [3:0] rx_left_q;
   logic rx_start_q;
   logic rxd_prev_q;

   wire [1:0] mode = {ctrl_q[MODE_SELECT_A], ctrl_q[MODE_SELECT_B]};
   wire m_shift = (mode == MODE_SHIFT);
   wire m_ten = (mode == MODE_ASYNC10);
   wire m_fixed = (mode == MODE_FIXED11);
   wire shift_tick = (sdiv_q == SHIFT_DIV_LAST);
   wire fix_last = baud_doubler ? (fdiv_q == FIX_LAST_FAST) : (fdiv_q == FIX_LAST_SLOW);
   wire fix_tick = fix_last;
   wire t1_tick = timer1_ovf & (baud_doubler | t1_half_q);
   wire tx_var = tx_rate_source ? timer2_ovf : t1_tick;
   wire rx_var = rx_rate_source ? timer2_ovf : t1_tick;
   wire tx_samp = m_fixed ? fix_tick : tx_var;
   wire rx_samp = m_fixed ? fix_tick : rx_var;
   wire tx_bit_tick = tx_samp & (tx_ovs_q == OVS_LAST);
   wire rx_event = rx_samp & (rx_div_q == 4'h0);

   always_ff @(posedge core_clk) begin
      if (rst || shift_tick) begin
         sdiv_q <= 4'h0;
      end else begin
         sdiv_q <= sdiv_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || fix_last) begin
         fdiv_q <= 2'h0;
      end else begin
         fdiv_q <= fdiv_q + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         t1_half_q <= 1'b0;
         tx_ovs_q <= 4'h0;
      end else begin
         t1_half_q <= t1_half_q ^ timer1_ovf;
         tx_ovs_q <= tx_samp ? tx_ovs_q + 4'h1 : tx_ovs_q;
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   wire tx_shift_busy = m_shift & (tx_state_q == DMU_TX_SEND);
   wire rx_shift_busy = (rx_state_q == DMU_RX_SHIFT);
   wire tx_step = m_shift ? shift_tick : tx_bit_tick;
   wire [10:0] tx_frame = {1'b1, m_ten ? 1'b1 : ctrl_q[TX_NINTH_BIT], wdata, 1'b0};
   wire tx_stop_start = ~m_shift & tx_step & (tx_left_q == 4'h2);
   wire tx_shift_end = m_shift & tx_step & (tx_left_q == 4'h1);
   wire ti_set = (tx_state_q == DMU_TX_SEND) & (tx_stop_start | tx_shift_end);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_state_q <= DMU_TX_IDLE;
         tx_shift_q <= 11'h7FF;
         tx_left_q <= 4'h0;
         tx_line_q <= 1'b1;
      end else if (data_wr) begin
         tx_state_q <= DMU_TX_WAIT;
         tx_shift_q <= m_shift ? {3'h7, wdata} : tx_frame;
         tx_left_q <= m_shift ? BITS_SHIFT : (m_ten ? BITS_TX10 : BITS_TX11);
      end else begin
         case (tx_state_q)
            DMU_TX_IDLE: begin
               tx_line_q <= 1'b1;
            end
            DMU_TX_WAIT: begin
               if (tx_step && !rx_shift_busy) begin
                  tx_state_q <= DMU_TX_SEND;
                  tx_line_q <= tx_shift_q[0];
               end
            end
            DMU_TX_SEND: begin
               if (tx_step) begin
                  tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                  tx_left_q <= tx_left_q - 4'h1;
                  tx_line_q <= tx_shift_q[1];
                  if (tx_left_q == 4'h1) begin
                     tx_state_q <= DMU_TX_IDLE;
                     tx_line_q <= 1'b1;
                  end
               end
            end
            default: begin
               tx_state_q <= DMU_TX_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   wire [9:0] rx_next = {rxd_in, rx_shift_q[9:1]};
   wire [7:0] rx_data = m_ten ? rx_next[8:1] : rx_next[7:0];
   wire rx_ninth = m_ten ? rx_next[9] : rx_next[8];
   wire start_edge = ~m_shift & ctrl_q[RX_ENABLE] & rxd_prev_q & ~rxd_in;
   wire shift_go = m_shift & ctrl_q[RX_ENABLE] & ~ctrl_q[RX_DONE_FLAG] & shift_tick
      & (tx_state_q == DMU_TX_IDLE) & ~data_wr;
   wire async_last = (rx_state_q == DMU_RX_ASYNC) & rx_event & ~rx_start_q
      & (rx_left_q == 4'h1);
   wire shift_last = rx_shift_busy & shift_tick & (rx_left_q == 4'h1);
   // An unread character blocks the new one; filtered ones are dropped
   wire async_accept = async_last & ~ctrl_q[RX_DONE_FLAG]
      & (~ctrl_q[ADDR_FILTER_EN] | rx_ninth);
   wire ri_set = async_accept | shift_last;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_state_q <= DMU_RX_IDLE;
         rx_shift_q <= 10'h000;
         rx_left_q <= 4'h0;
         rx_div_q <= 4'h0;
         rx_start_q <= 1'b0;
         rxd_prev_q <= 1'b1;
      end else begin
         rxd_prev_q <= rxd_in;
         case (rx_state_q)
            DMU_RX_IDLE: begin
               if (start_edge) begin
                  rx_state_q <= DMU_RX_ASYNC;
                  rx_div_q <= OVS_HALF;
                  rx_start_q <= 1'b1;
                  rx_left_q <= m_ten ? BITS_RX10 : BITS_RX11;
               end else if (shift_go) begin
                  rx_state_q <= DMU_RX_SHIFT;
                  rx_left_q <= BITS_SHIFT;
               end
            end
            DMU_RX_ASYNC: begin
               if (rx_samp) begin
                  rx_div_q <= (rx_div_q == 4'h0) ? OVS_LAST : rx_div_q - 4'h1;
               end
               if (rx_event) begin
                  rx_start_q <= 1'b0;
                  if (rx_start_q && rxd_in) begin
                     rx_state_q <= DMU_RX_IDLE;
                  end else if (!rx_start_q) begin
                     rx_shift_q <= rx_next;
                     rx_left_q <= rx_left_q - 4'h1;
                     if (rx_left_q == 4'h1) begin
                        rx_state_q <= DMU_RX_IDLE;
                     end
                  end
               end
            end
            DMU_RX_SHIFT: begin
               if (sdiv_q == SHIFT_SAMPLE) begin
                  rx_shift_q <= {2'h0, rxd_in, rx_shift_q[7:1]};
               end
               if (shift_tick) begin
                  rx_left_q <= rx_left_q - 4'h1;
                  if (rx_left_q == 4'h1) begin
                     rx_state_q <= DMU_RX_IDLE;
                  end
               end
            end
            default: begin
               rx_state_q <= DMU_RX_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers: hardware set wins over a software clear
   // ----------------------------------------------------------------
   logic [7:0] ctrl_d;
   always_comb begin
      ctrl_d = ctrl_wr ? wdata : ctrl_q;
      if (async_accept) begin
         ctrl_d[RX_NINTH_BIT] = rx_ninth;
      end
      ctrl_d[TX_DONE_FLAG] = ctrl_d[TX_DONE_FLAG] | ti_set;
      ctrl_d[RX_DONE_FLAG] = ctrl_d[RX_DONE_FLAG] | ri_set;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         rbuf_q <= DATA_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         if (async_accept) begin
            rbuf_q <= rx_data;
         end else if (shift_last) begin
            rbuf_q <= rx_shift_q[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   wire shift_clk = (tx_shift_busy | rx_shift_busy) ? (sdiv_q >= SHIFT_CLK_RISE) : 1'b1;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         txd_out <= 1'b1;
         rxd_out <= 1'b1;
         rxd_oe <= 1'b0;
      end else begin
         txd_out <= m_shift ? shift_clk : tx_line_q;
         rxd_out <= tx_shift_busy ? tx_line_q : 1'b1;
         rxd_oe <= tx_shift_busy;
      end
   end
endmodule

module dmu_uart #(
   parameter int unsigned NUM_PORTS = 2
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [1:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [NUM_PORTS-1:0] baud_doubler,
   input wire logic [NUM_PORTS-1:0] tx_rate_source,
   input wire logic [NUM_PORTS-1:0] rx_rate_source,
   input wire logic timer1_ovf,
   input wire logic timer2_ovf,
   input wire logic [NUM_PORTS-1:0] rxd_in,
   output logic [NUM_PORTS-1:0] rxd_out,
   output logic [NUM_PORTS-1:0] rxd_oe,
   output logic [NUM_PORTS-1:0] txd_out
);
   import dmu_pkg::*;

   if (NUM_PORTS != 2) begin : g_bad_ports
      $error("dmu_uart: address map serves exactly two ports");
   end

   logic [7:0] ctrl_v [NUM_PORTS];
   logic [7:0] rbuf_v [NUM_PORTS];
   wire sel_port = sfr_addr[ADDR_PORT_BIT];
   wire sel_data = sfr_addr[ADDR_DATA_BIT];

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      wire hit = sfr_wr & (sel_port == 1'(p));
      dmu_port u_port (
         .core_clk(core_clk),
         .rst(rst),
         .ctrl_wr(hit & ~sel_data),
         .data_wr(hit & sel_data),
         .wdata(sfr_wdata),
         .baud_doubler(baud_doubler[p]),
         .tx_rate_source(tx_rate_source[p]),
         .rx_rate_source(rx_rate_source[p]),
         .timer1_ovf(timer1_ovf),
         .timer2_ovf(timer2_ovf),
         .rxd_in(rxd_in[p]),
         .rxd_out(rxd_out[p]),
         .rxd_oe(rxd_oe[p]),
         .txd_out(txd_out[p]),
         .ctrl_q(ctrl_v[p]),
         .rbuf_q(rbuf_v[p])
      );
   end

   wire [7:0] rd_mux = sel_data ? rbuf_v[sel_port] : ctrl_v[sel_port];
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= rd_mux;
      end
   end
endmodule

`default_nettype wire

/* File: sim/dmu_uart_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

module dmu_uart_asserts #(
   parameter int unsigned NUM_PORTS = 2
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [1:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic [NUM_PORTS-1:0] baud_doubler,
   input wire logic [NUM_PORTS-1:0] rxd_out,
   input wire logic [NUM_PORTS-1:0] rxd_oe,
   input wire logic [NUM_PORTS-1:0] txd_out
);
   import dmu_pkg::*;
   // ---------------------------------------------------------------
   // Mode mirrors of both ports and run lengths on port 0
   // ---------------------------------------------------------------
   logic [1:0] mode0_q;
   logic [1:0] mode1_q;
   logic [11:0] low_q;
   logic [7:0] oe_q;
   always_ff @(posedge core_clk) begin
      if (rst || (sfr_wr && sfr_addr == ADDR_PORT0_CTRL))
         mode0_q <= rst ? MODE_SHIFT : sfr_wdata[7:6];
      if (rst || (sfr_wr && sfr_addr == ADDR_PORT1_CTRL))
         mode1_q <= rst ? MODE_SHIFT : sfr_wdata[7:6];
      low_q <= (rst || txd_out[0]) ? 12'h000 : low_q + 12'h001;
      oe_q <= (rst || !rxd_oe[0]) ? 8'h00 : oe_q + 8'h01;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_reset;
      disable iff (1'b0) rst |=> txd_out == '1 && rxd_oe == '0 && sfr_rdata == DATA_RESET;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs off reset level");
   property p_rdata_hold;
      !sfr_rd |=> $stable(sfr_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_oe_mode0;
      rxd_oe[0] |-> mode0_q == MODE_SHIFT;
   endproperty
   a_oe_mode0: assert property (p_oe_mode0) else $error("port 0 drives rx pin");
   property p_oe_mode1;
      rxd_oe[1] |-> mode1_q == MODE_SHIFT;
   endproperty
   a_oe_mode1: assert property (p_oe_mode1) else $error("port 1 drives rx pin");
   property p_shift_clk;
      $fell(txd_out[0]) && mode0_q == MODE_SHIFT |-> (!txd_out[0]) [*6] ##1 txd_out[0];
   endproperty
   a_shift_clk: assert property (p_shift_clk) else $error("shift clock shape");
   property p_shift_len;
      $fell(rxd_oe[0]) |-> oe_q >= 8'd95 && oe_q <= 8'd97;
   endproperty
   a_shift_len: assert property (p_shift_len) else $error("shift length");
   property p_shift_data;
      rxd_oe[0] && $changed(rxd_out[0]) |=> $stable(rxd_out[0]) [*8];
   endproperty
   a_shift_data: assert property (p_shift_data) else $error("shift data moved");
   property p_fixed_bit;
      $rose(txd_out[0]) && mode0_q == MODE_FIXED11 |-> low_q != 12'h000 &&
         (baud_doubler[0] ? low_q[4:0] == 5'h00 : low_q[5:0] == 6'h00);
   endproperty
   a_fixed_bit: assert property (p_fixed_bit) else $error("fixed bit time");
endmodule

bind dmu_uart dmu_uart_asserts #(.NUM_PORTS(NUM_PORTS)) dmu_uart_asserts_inst (.core_clk, .rst,
   .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .baud_doubler, .rxd_out, .rxd_oe,
   .txd_out);
`default_nettype wire

/* File: sim/dmu_remote.sv */
`timescale 1ns/100ps
`default_nettype none

module dmu_remote (
   input wire logic core_clk,
   input wire logic shift_mode,
   input wire logic [7:0] bit_clks,
   input wire logic txd,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   output var logic rxd,
   output var logic got,
   output var logic [8:0] word
);
   logic [8:0] w;
   logic [7:0] sw;
   logic [7:0] sh = 8'hFF;
   int n = 0;
   initial begin
      rxd = 1'b1;
      got = 1'b0;
      word = 9'h000;
   end
   task automatic fire(input logic [8:0] v);
      @(negedge core_clk);
      word = v;
      got = 1'b1;
      @(negedge core_clk);
      got = 1'b0;
   endtask
   // Start, nine bits after it, then a high stop
   task automatic send(input logic [8:0] v);
      rxd = 1'b0;
      repeat (bit_clks) @(negedge core_clk);
      for (int i = 0; i < 9; i++) begin
         rxd = v[i];
         repeat (bit_clks) @(negedge core_clk);
      end
      rxd = 1'b1;
      repeat (bit_clks) @(negedge core_clk);
   endtask
   task automatic load(input logic [7:0] b);
      sh = b;
   endtask
   initial begin
      forever begin
         @(negedge txd iff !shift_mode);
         repeat (bit_clks / 2) @(posedge core_clk);
         for (int i = 0; i < 9; i++) begin
            repeat (bit_clks) @(posedge core_clk);
            w[i] = txd;
         end
         fire(w);
      end
   end
   always @(posedge txd) begin
      if (shift_mode && rxd_oe) begin
         sw = {rxd_out, sw[7:1]};
         n++;
         if (n == 8) begin
            n = 0;
            fire({1'b0, sw});
         end
      end
   end
   always @(negedge txd) begin
      if (shift_mode && !rxd_oe) begin
         rxd <= sh[0];
         sh = {1'b1, sh[7:1]};
      end
   end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

module testbench;
   import dmu_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [1:0] sfr_addr = 2'h0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [1:0] baud_doubler = 2'h0;
   logic [1:0] tx_rate_source = 2'h0;
   logic [1:0] rx_rate_source = 2'h0;
   logic timer1_ovf = 1'b0;
   logic timer2_ovf = 1'b0;
   logic [7:0] sfr_rdata;
   logic [1:0] rxd_out, rxd_oe, txd_out;
   wire logic [1:0] rxd_in;
   logic rx_a, rx_b, got_a, got_b;
   logic sm0 = 1'b1;
   logic sm1 = 1'b0;
   logic rd_d = 1'b0;
   logic [8:0] word_a, word_b;
   logic [7:0] bc0 = 8'd64;
   logic [7:0] bc1 = 8'd64;
   logic [7:0] d, d2;
   logic [1:0] cyc = 2'h0;
   logic [7:0] q_rd[$];
   logic [8:0] q_t0[$], q_t1[$];
   int seed = 20649;
   int n_errors = 0;
   int checks_done = 0;
   assign rxd_in = {rx_b, rxd_oe[0] ? rxd_out[0] : rx_a};
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      cyc <= cyc + 2'h1;
      timer1_ovf <= cyc[0];
      timer2_ovf <= cyc == 2'h3;
   end
   dmu_uart #(.NUM_PORTS(2)) dmu_uart_inst (.core_clk, .rst, .sfr_wr, .sfr_rd, .sfr_addr,
      .sfr_wdata, .sfr_rdata, .baud_doubler, .tx_rate_source, .rx_rate_source, .timer1_ovf,
      .timer2_ovf, .rxd_in, .rxd_out, .rxd_oe, .txd_out);
   dmu_remote remote_a (.core_clk, .shift_mode(sm0), .bit_clks(bc0), .txd(txd_out[0]),
      .rxd_out(rxd_out[0]), .rxd_oe(rxd_oe[0]), .rxd(rx_a), .got(got_a), .word(word_a));
   dmu_remote remote_b (.core_clk, .shift_mode(sm1), .bit_clks(bc1), .txd(txd_out[1]),
      .rxd_out(rxd_out[1]), .rxd_oe(rxd_oe[1]), .rxd(rx_b), .got(got_b), .word(word_b));
   always @(posedge core_clk) begin
      if (rd_d)
         `CHK(sfr_rdata, q_rd.pop_front())
      rd_d <= sfr_rd;
      if (got_a)
         `CHK(word_a, q_t0.pop_front())
      if (got_b)
         `CHK(word_b, q_t1.pop_front())
   end
   // Read (w low) queues its expected value; write stores v
   task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] v);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = w;
      sfr_rd = !w;
      if (!w)
         q_rd.push_back(v);
      @(negedge core_clk);
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Frames end before the next setup; two bit times cover the stop
   task automatic wait_q();
      for (int i = 0; i < 3000 && q_t0.size() + q_t1.size() > 0; i++)
         @(posedge core_clk);
      if (q_t0.size() + q_t1.size() > 0) begin
         n_errors++;
         print_verdict();
      end
      repeat (140) @(negedge core_clk);
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      for (int a = 0; a < 4; a++)
         acc(1'b0, 2'(a), 8'h00);
      sm0 = 1'b0;
      for (int k = 0; k < 2; k++) begin
         d = 8'($random(seed));
         baud_doubler[0] = k[0];
         bc0 = k ? 8'd32 : 8'd64;
         acc(1'b1, 2'h0, 8'h88);
         q_t0.push_back({1'b1, d});
         acc(1'b1, 2'h1, d);
         wait_q();
         acc(1'b0, 2'h0, 8'h8A);
      end
      baud_doubler[0] = 1'b0;
      bc0 = 8'd64;
      d = 8'($random(seed));
      d2 = 8'($random(seed));
      acc(1'b1, 2'h0, 8'hB0);
      remote_a.send({1'b0, d});
      acc(1'b0, 2'h0, 8'hB0);
      acc(1'b0, 2'h1, 8'h00);
      remote_a.send({1'b1, d2});
      remote_a.send({1'b1, d});
      acc(1'b0, 2'h0, 8'hB5);
      acc(1'b0, 2'h1, d2);
      sm0 = 1'b1;
      acc(1'b1, 2'h0, 8'h00);
      q_t0.push_back({1'b0, d});
      acc(1'b1, 2'h1, d);
      wait_q();
      remote_a.load(d2);
      acc(1'b1, 2'h0, 8'h10);
      repeat (8 * 12 + 36) @(negedge core_clk);
      acc(1'b0, 2'h1, d2);
      acc(1'b0, 2'h0, 8'h11);
      // Second port still in shift mode from reset: one shifted byte
      sm1 = 1'b1;
      q_t1.push_back({1'b0, d2});
      acc(1'b1, 2'h3, d2);
      wait_q();
      sm1 = 1'b0;
      // Third pass: first timer with the doubler set, half the bit time
      for (int k = 0; k < 3; k++) begin
         d = 8'($random(seed));
         tx_rate_source[1] = k[0];
         rx_rate_source[1] = k[0];
         baud_doubler[1] = k[1];
         bc1 = k[1] ? 8'd32 : 8'd64;
         acc(1'b1, 2'h2, k ? 8'hC0 : 8'h40);
         q_t1.push_back({k == 0, d});
         acc(1'b1, 2'h3, d);
         wait_q();
      end
      acc(1'b1, 2'h2, 8'h70);
      remote_b.send({1'b0, d});
      acc(1'b0, 2'h2, 8'h70);
      remote_b.send({1'b1, d2});
      acc(1'b0, 2'h3, d2);
      acc(1'b0, 2'h2, 8'h75);
      repeat (4) @(negedge core_clk);
      print_verdict();
   end
endmodule
`default_nettype wire
